// ### pkg/imlx_pkg.sv
package imlx_pkg;
  localparam int NSRC = 14;
  localparam int NLINE = 4;
  localparam int FLD_W = 2;
  localparam logic [7:0] SENS_OFS = 8'h00;
  localparam logic [7:0] PSEL_OFS = 8'h04;
  localparam logic [7:0] PEND_OFS = 8'h08;
  localparam logic [7:0] SENS_RST = 8'h00;
  localparam logic [7:0] PSEL_RST = 8'h0C;
  localparam logic [3:0] LVL_RST = 4'hF;
  localparam logic [1:0] SNS_FALL_LOW = 2'h0;
  localparam logic [1:0] SNS_RISE = 2'h1;
  localparam logic [1:0] SNS_FALL = 2'h2;
  localparam logic [1:0] SNS_BOTH = 2'h3;
  localparam logic [1:0] PB4_CODE = 2'h1;
  localparam logic [1:0] L3_NONE = 2'h3;
  localparam logic [2:0] L0_BASE = 3'h0;
  localparam logic [2:0] L1_BASE = 3'h4;
  localparam logic [2:0] L2_BASE = 3'h3;
  localparam logic [2:0] L3_BASE = 3'h0;
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP = 16'hFFFC;
  localparam logic [15:0] VEC_SRC0 = 16'hFFFA;
  localparam logic [13:0] USED_SRC = 14'h3F21;
  localparam logic [13:0] HALT_WAKE = 14'h101E;
  localparam logic [13:0] ACTV_WAKE = 14'h1A1E;
  localparam logic [13:0] AWU_WAKE = 14'h101F;
  localparam logic [4:0] SRC_RESET = 5'h10;
  localparam logic [4:0] SRC_TRAP = 5'h11;
  localparam logic [4:0] SRC_NONE = 5'h1F;
  typedef enum logic [1:0] {PM_RUN, PM_HALT, PM_ACT_HALT, PM_AWU_HALT} imlx_pwr_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } imlx_wb_req_t;
  typedef struct packed {
    logic mask;
    logic trap;
    logic ack;
    imlx_pwr_t mode;
  } imlx_core_t;
  typedef struct packed {
    logic [7:0] sens;
    logic [7:0] psel;
    logic [3:0] pend;
    logic [3:0] lvl;
    logic rst_pend;
    logic trap_pend;
    logic req;
    logic [15:0] vec;
    logic [4:0] src;
    logic wake;
    logic ack;
    logic [31:0] rdat;
  } imlx_state_t;
endpackage

// ### hdl/imlx_ctrl.sv
// What this block does
// - pending requests served in order reset, trap, then source 0 up to 13.
// - source 0 vectors FFFAh, wakes only from auto-wake-up halt.
// - source 5 vectors FFF0h and never wakes from any halt.
// - source 8 vectors FFEAh and does not wake.
// - source 9 vectors FFE8h; source 13 vectors FFE0h and never wakes.
// - source 10 vectors FFE6h and never wakes from halt.
// - source 11 vectors FFE4h.
// - sources 9 and 11 wake only from active halt.
// - sensitivity register has one 2-bit field per line, line 3 at top.
// - field codes: fall plus low, rise, fall, both edges.
// - sensitivity writes take effect only while the core mask bit is set.
// - changing a line's sensitivity field drops its pending request.
// - sensitivity register resets to zero.
// - pin select register resets to 0Ch.
// - line 3 takes port B bit 0, 1 or 2.
// - line 2 takes port B bit 3, 4, 5 or 6.
// - port B bit 4 on line 2 is ignored while in halt.
// - line 1 takes port A bit 4, 5, 6 or 7.
// - line 0 takes port A bit 0, 1, 2 or 3.
// - edge requests are latched and cleared when their vector is taken.
// - edge requests wait latched while the mask bit is set.
`timescale 1ns/1ps
module imlx_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire imlx_pkg::imlx_wb_req_t wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack,
  input wire imlx_pkg::imlx_core_t core,
  input wire logic [13:0] periph_irq,
  input wire logic [7:0] port_a,
  input wire logic [7:0] port_b,
  output logic irq_req,
  output logic [15:0] irq_vec,
  output logic [4:0] irq_src,
  output logic wake
);

  imlx_pkg::imlx_state_t s;
  imlx_pkg::imlx_state_t next_s;

  function automatic logic [1:0] fld(input logic [7:0] r, input int k);
    fld = r[k*imlx_pkg::FLD_W +: imlx_pkg::FLD_W];
  endfunction

  function automatic logic [15:0] src_vec(input logic [3:0] n);
    src_vec = imlx_pkg::VEC_SRC0 - {11'h000, n, 1'b0};
  endfunction

  function automatic logic pin_of(input int k, input logic [1:0] c,
                                  input logic [7:0] pa, input logic [7:0] pb);
    logic [2:0] b;
    b = {1'b0, c};
    case (k)
      0: pin_of = pa[imlx_pkg::L0_BASE + b];
      1: pin_of = pa[imlx_pkg::L1_BASE + b];
      2: pin_of = pb[imlx_pkg::L2_BASE + b];
      default: pin_of = pb[imlx_pkg::L3_BASE + b];
    endcase
  endfunction

  function automatic logic [13:0] wake_mask(input imlx_pkg::imlx_pwr_t m);
    case (m)
      imlx_pkg::PM_HALT: wake_mask = imlx_pkg::HALT_WAKE;
      imlx_pkg::PM_ACT_HALT: wake_mask = imlx_pkg::ACTV_WAKE;
      imlx_pkg::PM_AWU_HALT: wake_mask = imlx_pkg::AWU_WAKE;
      default: wake_mask = 14'h0000;
    endcase
  endfunction

  logic [3:0] cur;
  logic [3:0] dis;
  logic [3:0] set;
  logic [3:0] clr;
  logic [3:0] lvl_req;
  logic [13:0] src_req;
  logic wb_go;
  logic wr_sens;
  logic wr_psel;
  logic took;
  logic [4:0] pick;
  logic [15:0] pick_vec;

  always_comb begin
    next_s = s;
    next_s.ack = 1'b0;
    cur = 4'h0;
    dis = 4'h0;
    set = 4'h0;
    clr = 4'h0;
    lvl_req = 4'h0;
    pick = imlx_pkg::SRC_NONE;
    pick_vec = 16'h0000;
    took = core.ack && s.req;

    // bus decode; one wait-free answer per request
    wb_go = wb_req.cyc && wb_req.stb && !s.ack;
    wr_sens = wb_go && wb_req.we && wb_req.sel[0] && wb_req.adr == imlx_pkg::SENS_OFS;
    wr_psel = wb_go && wb_req.we && wb_req.sel[0] && wb_req.adr == imlx_pkg::PSEL_OFS;
    if (wb_go) begin
      next_s.ack = 1'b1;
    end
    if (wr_sens && core.mask) begin
      next_s.sens = wb_req.dat[7:0];
    end
    if (wr_psel) begin
      next_s.psel = wb_req.dat[7:0];
    end

    for (int k = 0; k < imlx_pkg::NLINE; k++) begin
      // a blocked input freezes at its last level, so it raises no edge while blocked
      dis[k] = (k == 2 && fld(s.psel, 2) == imlx_pkg::PB4_CODE
                && core.mode != imlx_pkg::PM_RUN)
               || (k == 3 && fld(s.psel, 3) == imlx_pkg::L3_NONE);
      cur[k] = dis[k] ? s.lvl[k] : pin_of(k, fld(s.psel, k), port_a, port_b);
      case (fld(s.sens, k))
        imlx_pkg::SNS_RISE: set[k] = cur[k] && !s.lvl[k];
        imlx_pkg::SNS_BOTH: set[k] = cur[k] != s.lvl[k];
        default: set[k] = !cur[k] && s.lvl[k];
      endcase
      lvl_req[k] = fld(s.sens, k) == imlx_pkg::SNS_FALL_LOW && !s.lvl[k] && !dis[k];
      clr[k] = took && s.src == 5'(k + 1);
      next_s.lvl[k] = cur[k];
      // the taken request clears, but a fresh edge in that cycle is kept
      next_s.pend[k] = (s.pend[k] && !clr[k]) || set[k];
      if (wr_sens && core.mask && wb_req.dat[k*2 +: 2] != fld(s.sens, k)) begin
        next_s.pend[k] = 1'b0;
      end
    end

    src_req = periph_irq & imlx_pkg::USED_SRC;
    src_req[4:1] = s.pend | lvl_req;

    // read mux sits after src_req so the pending word shows this cycle's requests
    if (wb_go) begin
      case (wb_req.adr)
        imlx_pkg::SENS_OFS: next_s.rdat = {24'h000000, s.sens};
        imlx_pkg::PSEL_OFS: next_s.rdat = {24'h000000, s.psel};
        imlx_pkg::PEND_OFS: next_s.rdat = {16'h0000, s.rst_pend, s.trap_pend, src_req};
        default: next_s.rdat = 32'h00000000;
      endcase
    end

    if (took && s.src == imlx_pkg::SRC_RESET) begin
      next_s.rst_pend = 1'b0;
    end
    next_s.trap_pend = (s.trap_pend && !(took && s.src == imlx_pkg::SRC_TRAP)) || core.trap;

    // fixed order, lowest index wins
    for (int n = imlx_pkg::NSRC - 1; n >= 0; n--) begin
      if (src_req[n]) begin
        pick = 5'(n);
        pick_vec = src_vec(4'(n));
      end
    end
    if (core.mask) begin
      pick = imlx_pkg::SRC_NONE;
    end
    if (s.trap_pend) begin
      pick = imlx_pkg::SRC_TRAP;
      pick_vec = imlx_pkg::VEC_TRAP;
    end
    if (s.rst_pend) begin
      pick = imlx_pkg::SRC_RESET;
      pick_vec = imlx_pkg::VEC_RESET;
    end
    // one idle cycle after each take, so the old vector is never taken twice
    next_s.req = !took && pick != imlx_pkg::SRC_NONE;
    next_s.src = next_s.req ? pick : imlx_pkg::SRC_NONE;
    next_s.vec = next_s.req ? pick_vec : 16'h0000;
    next_s.wake = |(src_req & wake_mask(core.mode));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.sens <= imlx_pkg::SENS_RST;
      s.psel <= imlx_pkg::PSEL_RST;
      s.lvl <= imlx_pkg::LVL_RST;
      s.rst_pend <= 1'b1;
      s.src <= imlx_pkg::SRC_NONE;
    end else begin
      s <= next_s;
    end
  end

  assign wb_dat_o = s.rdat;
  assign wb_ack = s.ack;
  assign irq_req = s.req;
  assign irq_vec = s.vec;
  assign irq_src = s.src;
  assign wake = s.wake;

  logic past_mask;
  logic past_took;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      past_mask <= 1'b1;
      past_took <= 1'b0;
    end else begin
      past_mask <= core.mask;
      past_took <= took;
    end
  end

  property p_wb_answer;
    @(posedge clk) disable iff (!rst_n)
      (wb_req.cyc && wb_req.stb && !wb_ack) |=> wb_ack ##1 !wb_ack;
  endproperty
  a_wb_answer: assert property (p_wb_answer) else $error("bus answer not one cycle");

  property p_sens_locked;
    @(posedge clk) disable iff (!rst_n)
      (wr_sens && !core.mask) |=> $stable(s.sens);
  endproperty
  a_sens_locked: assert property (p_sens_locked) else $error("sens written while unmasked");

  property p_sens_store;
    @(posedge clk) disable iff (!rst_n)
      (wr_sens && core.mask) |=> s.sens == $past(wb_req.dat[7:0]);
  endproperty
  a_sens_store: assert property (p_sens_store) else $error("sens write lost");

  property p_sens_clear;
    @(posedge clk) disable iff (!rst_n)
      (wr_sens && core.mask && wb_req.dat[1:0] != s.sens[1:0]) |=> !s.pend[0];
  endproperty
  a_sens_clear: assert property (p_sens_clear) else $error("pending kept on sense change");

  property p_reset_first;
    @(posedge clk) disable iff (!rst_n)
      (irq_req && s.rst_pend) |-> irq_vec == imlx_pkg::VEC_RESET;
  endproperty
  a_reset_first: assert property (p_reset_first) else $error("reset not served first");

  property p_src_vec;
    @(posedge clk) disable iff (!rst_n)
      (irq_req && irq_src < 5'(imlx_pkg::NSRC))
        |-> irq_vec == imlx_pkg::VEC_SRC0 - {10'h000, irq_src, 1'b0};
  endproperty
  a_src_vec: assert property (p_src_vec) else $error("source vector wrong");

  property p_masked;
    @(posedge clk) disable iff (!rst_n)
      (irq_req && irq_src < 5'(imlx_pkg::NSRC)) |-> !past_mask;
  endproperty
  a_masked: assert property (p_masked) else $error("request served while masked");

  property p_take_gap;
    @(posedge clk) disable iff (!rst_n)
      past_took |-> !irq_req;
  endproperty
  a_take_gap: assert property (p_take_gap) else $error("request held after take");

  property p_reset_take;
    @(posedge clk) disable iff (!rst_n)
      (took && irq_src == imlx_pkg::SRC_RESET) |=> !s.rst_pend;
  endproperty
  a_reset_take: assert property (p_reset_take) else $error("reset request not cleared");

  property p_halt_wake;
    @(posedge clk) disable iff (!rst_n)
      (core.mode == imlx_pkg::PM_HALT && src_req == 14'h0001) |=> !wake;
  endproperty
  a_halt_wake: assert property (p_halt_wake) else $error("source 0 woke plain halt");

  property p_line3_off;
    @(posedge clk) disable iff (!rst_n)
      (fld(s.psel, 3) == imlx_pkg::L3_NONE && !s.pend[3]) |=> !s.pend[3];
  endproperty
  a_line3_off: assert property (p_line3_off) else $error("line 3 fired with no pin");

  property p_vec_idle;
    @(posedge clk) disable iff (!rst_n)
      !irq_req |-> (irq_vec == 16'h0000 && irq_src == imlx_pkg::SRC_NONE);
  endproperty
  a_vec_idle: assert property (p_vec_idle) else $error("vector shown while idle");

  property p_trap_vec;
    @(posedge clk) disable iff (!rst_n)
      (irq_req && irq_src == imlx_pkg::SRC_TRAP) |-> irq_vec == imlx_pkg::VEC_TRAP;
  endproperty
  a_trap_vec: assert property (p_trap_vec) else $error("trap vector wrong");

  property p_reset_vec;
    @(posedge clk) disable iff (!rst_n)
      (irq_req && irq_src == imlx_pkg::SRC_RESET) |-> irq_vec == imlx_pkg::VEC_RESET;
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("reset vector wrong");

  property p_no_unused;
    @(posedge clk) disable iff (!rst_n)
      irq_req |-> (irq_src != 5'h06 && irq_src != 5'h07);
  endproperty
  a_no_unused: assert property (p_no_unused) else $error("unused source offered");

  property p_psel_store;
    @(posedge clk) disable iff (!rst_n)
      wr_psel |=> s.psel == $past(wb_req.dat[7:0]);
  endproperty
  a_psel_store: assert property (p_psel_store) else $error("pin select write lost");

  property p_sens_clear1;
    @(posedge clk) disable iff (!rst_n)
      (wr_sens && core.mask && wb_req.dat[3:2] != s.sens[3:2]) |=> !s.pend[1];
  endproperty
  a_sens_clear1: assert property (p_sens_clear1) else $error("line 1 kept pending");

  property p_sens_clear2;
    @(posedge clk) disable iff (!rst_n)
      (wr_sens && core.mask && wb_req.dat[5:4] != s.sens[5:4]) |=> !s.pend[2];
  endproperty
  a_sens_clear2: assert property (p_sens_clear2) else $error("line 2 kept pending");

  property p_sens_clear3;
    @(posedge clk) disable iff (!rst_n)
      (wr_sens && core.mask && wb_req.dat[7:6] != s.sens[7:6]) |=> !s.pend[3];
  endproperty
  a_sens_clear3: assert property (p_sens_clear3) else $error("line 3 kept pending");

  property p_pend_hold;
    @(posedge clk) disable iff (!rst_n)
      (s.pend[0] && !clr[0] && !(wr_sens && core.mask)) |=> s.pend[0];
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pending line 0 lost");

  property p_fall_set;
    @(posedge clk) disable iff (!rst_n)
      (fld(s.sens, 0) == imlx_pkg::SNS_FALL && s.lvl[0] && !cur[0]
       && !(wr_sens && core.mask)) |=> s.pend[0];
  endproperty
  a_fall_set: assert property (p_fall_set) else $error("falling edge not latched");

  property p_rise_set;
    @(posedge clk) disable iff (!rst_n)
      (fld(s.sens, 1) == imlx_pkg::SNS_RISE && !s.lvl[1] && cur[1]
       && !(wr_sens && core.mask)) |=> s.pend[1];
  endproperty
  a_rise_set: assert property (p_rise_set) else $error("rising edge not latched");

  property p_rise_quiet;
    @(posedge clk) disable iff (!rst_n)
      (fld(s.sens, 1) == imlx_pkg::SNS_RISE && !s.pend[1] && (s.lvl[1] || !cur[1]))
        |=> !s.pend[1];
  endproperty
  a_rise_quiet: assert property (p_rise_quiet) else $error("rise mode fired on fall");

  property p_pb4_halt;
    @(posedge clk) disable iff (!rst_n)
      (fld(s.psel, 2) == imlx_pkg::PB4_CODE && core.mode != imlx_pkg::PM_RUN && !s.pend[2])
        |=> !s.pend[2];
  endproperty
  a_pb4_halt: assert property (p_pb4_halt) else $error("port b bit 4 fired in halt");

  property p_src_clear;
    @(posedge clk) disable iff (!rst_n)
      (took && irq_src == 5'h01 && s.lvl[0] == cur[0]) |=> !s.pend[0];
  endproperty
  a_src_clear: assert property (p_src_clear) else $error("taken edge not cleared");

  property p_wake_run;
    @(posedge clk) disable iff (!rst_n)
      core.mode == imlx_pkg::PM_RUN |=> !wake;
  endproperty
  a_wake_run: assert property (p_wake_run) else $error("wake raised in run");

  property p_wake_src5;
    @(posedge clk) disable iff (!rst_n)
      (core.mode != imlx_pkg::PM_RUN && src_req == 14'h0020) |=> !wake;
  endproperty
  a_wake_src5: assert property (p_wake_src5) else $error("source 5 woke a halt");

  property p_wake_act;
    @(posedge clk) disable iff (!rst_n)
      (core.mode == imlx_pkg::PM_ACT_HALT && src_req[9]) |=> wake;
  endproperty
  a_wake_act: assert property (p_wake_act) else $error("source 9 did not wake");

  c_ext_take: cover property (@(posedge clk) disable iff (!rst_n)
    took && irq_src == 5'h01);
  c_trap_take: cover property (@(posedge clk) disable iff (!rst_n)
    took && irq_src == imlx_pkg::SRC_TRAP);
  c_wake_act: cover property (@(posedge clk) disable iff (!rst_n)
    core.mode == imlx_pkg::PM_ACT_HALT && wake);
  c_sens_write: cover property (@(posedge clk) disable iff (!rst_n)
    wr_sens && core.mask);
  c_fall_latch: cover property (@(posedge clk) disable iff (!rst_n)
    fld(s.sens, 0) == imlx_pkg::SNS_FALL && s.lvl[0] && !cur[0]);

endmodule

// ### test/imlx_core_model.sv
`timescale 1ns/1ps
module imlx_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic irq_req,
  input wire logic [15:0] irq_vec,
  input wire logic [4:0] irq_src,
  input wire logic mask_i,
  input wire imlx_pkg::imlx_pwr_t mode_i,
  input wire logic trap_i,
  input wire logic [13:0] set_irq,
  input wire logic ack_en,
  input wire logic [3:0] dly,
  output imlx_pkg::imlx_core_t core,
  output logic [13:0] periph_irq,
  output logic [15:0] last_vec,
  output logic took
);
  logic ack;
  logic take;
  logic [3:0] cnt;
  logic [13:0] clr;
  assign take = ack && irq_req;
  assign core = '{mask: mask_i, trap: trap_i, ack: ack, mode: mode_i};
  // a served source drops its flag, as its routine would clear it
  assign clr = (take && irq_src < 5'hE) ? (14'h1 << irq_src) : 14'h0;
  // dly holds the take back to model a long instruction still running
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      cnt <= 4'h0;
      took <= 1'b0;
      last_vec <= 16'h0;
      periph_irq <= 14'h0;
    end else begin
      ack <= irq_req && !ack && ack_en && cnt >= dly;
      cnt <= (irq_req && !ack) ? cnt + 4'h1 : 4'h0;
      took <= take;
      if (take) begin
        last_vec <= irq_vec;
      end
      periph_irq <= (periph_irq | set_irq) & ~clr;
    end
  end
endmodule

// ### test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk, rst_n, wb_ack, irq_req, wake, trap_i, ack_en, mask_i, took;
  imlx_pkg::imlx_wb_req_t wb_req;
  imlx_pkg::imlx_core_t core;
  imlx_pkg::imlx_pwr_t mode_i;
  logic [31:0] wb_dat_o, q;
  logic [13:0] periph_irq, set_irq;
  logic [7:0] port_a, port_b;
  logic [15:0] irq_vec, last_vec;
  logic [4:0] irq_src;
  logic [3:0] dly;
  int fail_count, num_checks, cycles;
  int srcs[7] = '{0, 5, 8, 9, 10, 11, 13};
  logic [2:0] wk[7] = '{3'h4, 3'h0, 3'h0, 3'h2, 3'h0, 3'h2, 3'h0};
  logic [3:0] fall_e[4] = '{4'hF, 4'h0, 4'hF, 4'hF};
  logic [3:0] rise_e[4] = '{4'h0, 4'hF, 4'h0, 4'hF};
  logic [7:0] sv[4] = '{8'h00, 8'h55, 8'hAA, 8'hFF};
  imlx_ctrl i_dut (.clk(clk), .rst_n(rst_n), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
    .wb_ack(wb_ack), .core(core), .periph_irq(periph_irq), .port_a(port_a),
    .port_b(port_b), .irq_req(irq_req), .irq_vec(irq_vec), .irq_src(irq_src), .wake(wake));
  imlx_core_model i_core (.clk(clk), .rst_n(rst_n), .irq_req(irq_req), .irq_vec(irq_vec),
    .irq_src(irq_src), .mask_i(mask_i), .mode_i(mode_i), .trap_i(trap_i),
    .set_irq(set_irq), .ack_en(ack_en), .dly(dly), .core(core),
    .periph_irq(periph_irq), .last_vec(last_vec), .took(took));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // the ceiling sits far above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      $display("unexpected at %0t: timeout", $time);
      fail_count++;
      test_done();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'h1, dat: {24'h0, d}};
    do @(posedge clk); while (wb_ack !== 1'b1);
    q = wb_dat_o;
    wb_req <= '0;
    @(posedge clk);
  endtask
  task wait_take();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (took !== 1'b1 && n < 60);
    chk(took, 1);
  endtask
  task pins(input logic v);
    port_a <= {3'h7, v, v, 3'h7};
    port_b <= {1'b1, v, 3'h7, v, 2'h3};
    tick(3);
  endtask
  initial begin
    rst_n = 1'b0;
    wb_req = '0;
    mask_i = 1'b1;
    mode_i = imlx_pkg::PM_RUN;
    trap_i = 1'b0;
    set_irq = 14'h0;
    ack_en = 1'b0;
    dly = 4'h0;
    port_a = 8'hFF;
    port_b = 8'hFF;
    fail_count = 0;
    num_checks = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    tick(2);
    chk(irq_src, 32'h10);
    wb(0, imlx_pkg::SENS_OFS, 8'h0);
    chk(q, 32'h0);
    wb(0, imlx_pkg::PSEL_OFS, 8'h0);
    chk(q, 32'h0C);
    wb(0, 8'h10, 8'h0);
    chk(q, 32'h0);
    ack_en <= 1'b1;
    wait_take();
    chk(last_vec, 32'hFFFE);
    trap_i <= 1'b1;
    tick(1);
    trap_i <= 1'b0;
    wait_take();
    chk(last_vec, 32'hFFFC);
    for (int i = 0; i < 7; i++) begin
      dly <= 4'(i);
      set_irq <= 14'h1 << srcs[i];
      tick(1);
      set_irq <= 14'h0;
      for (int m = 1; m < 4; m++) begin
        mode_i <= imlx_pkg::imlx_pwr_t'(m);
        tick(3);
        chk(wake, wk[i][m-1]);
      end
      chk(irq_req, 0);
      mode_i <= imlx_pkg::PM_RUN;
      mask_i <= 1'b0;
      wait_take();
      chk(last_vec, 16'hFFFA - 2 * srcs[i]);
      mask_i <= 1'b1;
    end
    set_irq <= 14'h2F21;
    tick(1);
    set_irq <= 14'h0;
    tick(2);
    mask_i <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      wait_take();
      chk(last_vec, 16'hFFFA - 2 * srcs[i]);
    end
    wb(1, imlx_pkg::PSEL_OFS, 8'hB3);
    wb(1, imlx_pkg::SENS_OFS, 8'hFF);
    wb(0, imlx_pkg::SENS_OFS, 8'h0);
    chk(q, 32'h0);
    mask_i <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      pins(1'b1);
      wb(1, imlx_pkg::SENS_OFS, sv[c]);
      pins(1'b0);
      wb(0, imlx_pkg::PEND_OFS, 8'h0);
      chk(q[4:1], fall_e[c]);
      wb(1, imlx_pkg::SENS_OFS, (c == 1) ? 8'hAA : 8'h55);
      wb(1, imlx_pkg::SENS_OFS, sv[c]);
      pins(1'b1);
      wb(0, imlx_pkg::PEND_OFS, 8'h0);
      chk(q[4:1], rise_e[c]);
    end
    mask_i <= 1'b0;
    for (int n = 0; n < 4; n++) begin
      wait_take();
      chk(last_vec, 16'hFFF8 - 2 * n);
    end
    wb(0, imlx_pkg::PEND_OFS, 8'h0);
    chk(q[4:1], 0);
    wb(1, imlx_pkg::PSEL_OFS, 8'hD3);
    mask_i <= 1'b1;
    mode_i <= imlx_pkg::PM_HALT;
    port_b <= 8'hE8;
    tick(3);
    wb(0, imlx_pkg::PEND_OFS, 8'h0);
    chk(q[4:3], 0);
    test_done();
  end
endmodule
